// File: src/csr_poll_pkg.sv
package csr_poll_pkg;
    localparam logic [7:0] PTR_WIO_OFF = 8'h12;
    localparam logic [7:0] PTR_DOUBLE_WORD_IO_MODE_OFF = 8'h14;
    localparam logic [7:0] CSR_DATA_OFF = 8'h10;
    localparam logic [7:0] BCR_DATA_WIO_OFF = 8'h16;
    localparam logic [15:0] MMIO_POLL_OFF = 16'h0188;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [15:0] POLL_RESET = 16'h0000;
    localparam int POLL_GRAN_LSB = 4;
    localparam logic [11:0] POLL_TICK_MAX = 12'hFFF;
    localparam int CSR_POLL_IDX = 47;
    localparam int PTR_W = 8;
    localparam int POLL_W = 16;
endpackage : csr_poll_pkg

// File: src/poll_cfg_if.sv
`timescale 1ns/1ns
interface poll_cfg_if;
    logic [15:0] interval;
    logic reload;
    logic demand;
    logic poll;
    modport ctrl
    (
        output interval,
        output reload,
        output demand,
        input poll
    );
    modport timer
    (
        input interval,
        input reload,
        input demand,
        output poll
    );
endinterface : poll_cfg_if

// File: src/tx_poll_timer.sv
`timescale 1ns/1ns
module tx_poll_timer
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic ref_tick,
    poll_cfg_if.timer cfg
);
    logic [11:0] cnt_r;
    logic [11:0] cnt_nxt;
    logic poll_r;
    logic poll_nxt;

    // Counts up one per ref_tick (16 core periods) from the negated interval; bit 16 implied set
    always_comb
    begin
        cnt_nxt = cnt_r;
        poll_nxt = 1'b0;
        if (cfg.demand)
        begin
            poll_nxt = 1'b1;
            cnt_nxt = cfg.interval[15:4];
        end
        else if (cfg.reload)
        begin
            cnt_nxt = cfg.interval[15:4];
        end
        else if (ref_tick)
        begin
            if (cnt_r == csr_poll_pkg::POLL_TICK_MAX)
            begin
                poll_nxt = 1'b1;
                cnt_nxt = cfg.interval[15:4];
            end
            else
            begin
                cnt_nxt = cnt_r + 12'h001;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            cnt_r <= 12'h000;
            poll_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            poll_r <= poll_nxt;
        end
    end

    assign cfg.poll = poll_r;
endmodule : tx_poll_timer

// File: src/ref_tick_div.sv
`timescale 1ns/1ns
module ref_tick_div
(
    input wire logic core_clk,
    input wire logic reset,
    output logic tick16
);
    logic [3:0] div_r;
    logic [3:0] div_nxt;
    logic tick_r;
    logic tick_nxt;

    // Sixteen core periods stand for one 16-period interval unit
    always_comb
    begin
        div_nxt = div_r + 4'h1;
        tick_nxt = (div_r == 4'hF);
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            div_r <= 4'h0;
            tick_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick16 = tick_r;
endmodule : ref_tick_div

// File: src/indirect_csr_access.sv
// Overview of operation
// - Chip reset, pre-load and load failure clear the poll interval.
// - Interval holds the negated count of reference periods between polls.
// - Low four interval bits are ignored; sixteen-period granularity.
// - Implied seventeenth bit is one, so bit 15 is magnitude.
// - Stored zero means 65,536 periods between polls.
// - Init command restores the interval to zero.
// - Low eight pointer bits index the data port target.
// - One pointer serves both status and bus-configuration data ports.
// - Pointer sits at 12h in word mode, 14h in double-word mode.
// - Status data port sits at 10h in both modes.
// - Bus-configuration data port sits at 16h in word mode.
// - Pointer bits 15-8 read zero; bits 31-16 undefined, read zero here.
// - Undefined indexes read undefined; writes may alter control state.
// - Hardware or software reset clears pointer; stop leaves it.
// - Each status access goes to the register the pointer names then.
// - Status registers are reachable at any time, even running.
// - Transmit demand forces an immediate ring poll.
`timescale 1ns/1ns
module indirect_csr_access
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic soft_reset,
    input wire logic eeprom_busy,
    input wire logic eeprom_error,
    input wire logic init_cmd,
    input wire logic stop_cmd,
    input wire logic tx_demand_bit,
    input wire logic double_word_io_mode,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [31:0] io_wdata,
    input wire logic mem_wr,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [31:0] io_rdata,
    output logic [7:0] reg_index,
    output logic csr_wr,
    output logic csr_rd,
    output logic bcr_wr,
    output logic bcr_rd,
    output logic [15:0] tx_poll_interval,
    output logic tx_poll
);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic is_ptr(input logic [7:0] a, input logic dw);
        is_ptr = dw ? (a == csr_poll_pkg::PTR_DOUBLE_WORD_IO_MODE_OFF) : (a == csr_poll_pkg::PTR_WIO_OFF);
    endfunction : is_ptr

    function automatic logic is_bcr(input logic [7:0] a, input logic dw);
        is_bcr = !dw && (a == csr_poll_pkg::BCR_DATA_WIO_OFF);
    endfunction : is_bcr

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ptr_r;
    logic [7:0] ptr_nxt;
    logic [15:0] poll_r;
    logic [15:0] poll_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic csr_wr_r;
    logic csr_wr_nxt;
    logic csr_rd_r;
    logic csr_rd_nxt;
    logic bcr_wr_r;
    logic bcr_wr_nxt;
    logic bcr_rd_r;
    logic bcr_rd_nxt;
    logic reload_r;
    logic reload_nxt;
    logic demand_r;
    logic demand_nxt;
    logic poll_out_r;
    logic poll_out_nxt;
    logic tick16;
    logic csr_hit;
    logic poll_csr_hit;
    logic ptr_hit;
    logic bcr_hit;
    logic mem_hit;
    logic clear_poll;

    poll_cfg_if cfg();

    ref_tick_div u_div
    (
        .core_clk(core_clk),
        .reset(reset),
        .tick16(tick16)
    );

    tx_poll_timer u_timer
    (
        .core_clk(core_clk),
        .reset(reset),
        .ref_tick(tick16),
        .cfg(cfg)
    );

    assign cfg.interval = poll_r;
    assign cfg.reload = reload_r;
    assign cfg.demand = demand_r;

    ////////////////////////////////////////////////////////////////////////
    // Status port decoded in both modes, never gated by run state
    assign csr_hit = (io_addr == csr_poll_pkg::CSR_DATA_OFF);
    assign ptr_hit = is_ptr(io_addr, double_word_io_mode);
    assign bcr_hit = is_bcr(io_addr, double_word_io_mode);
    assign poll_csr_hit = csr_hit && (ptr_r == 8'(csr_poll_pkg::CSR_POLL_IDX));
    assign mem_hit = mem_wr && (mem_addr == csr_poll_pkg::MMIO_POLL_OFF);
    // A load in progress or failed holds the interval at its default
    assign clear_poll = init_cmd || eeprom_busy || eeprom_error;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        ptr_nxt = ptr_r;
        if (io_wr && ptr_hit)
        begin
            ptr_nxt = io_wdata[7:0];
        end
        // Stop keeps the index so software can carry on where it was
        if (stop_cmd)
        begin
            ptr_nxt = ptr_nxt;
        end
        if (soft_reset)
        begin
            ptr_nxt = csr_poll_pkg::PTR_RESET;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            ptr_r <= csr_poll_pkg::PTR_RESET;
        end
        else
        begin
            ptr_r <= ptr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        poll_nxt = poll_r;
        reload_nxt = 1'b0;
        if (mem_hit)
        begin
            poll_nxt = mem_wdata;
            reload_nxt = 1'b1;
        end
        else if (io_wr && poll_csr_hit)
        begin
            poll_nxt = io_wdata[15:0];
            reload_nxt = 1'b1;
        end
        // Clear beats a same-cycle write, so software writes after init
        if (clear_poll)
        begin
            poll_nxt = csr_poll_pkg::POLL_RESET;
            reload_nxt = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            poll_r <= csr_poll_pkg::POLL_RESET;
            reload_r <= 1'b0;
        end
        else
        begin
            poll_r <= poll_nxt;
            reload_r <= reload_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (io_rd)
        begin
            // Unknown indexes read zero; outside logic supplies real contents
            rdata_nxt = 32'h0000_0000;
            if (ptr_hit)
            begin
                rdata_nxt = {24'h00_0000, ptr_r};
            end
            else if (poll_csr_hit)
            begin
                rdata_nxt = {16'h0000, poll_r};
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        csr_wr_nxt = io_wr && csr_hit;
        bcr_wr_nxt = io_wr && bcr_hit;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            csr_wr_r <= 1'b0;
            bcr_wr_r <= 1'b0;
        end
        else
        begin
            csr_wr_r <= csr_wr_nxt;
            bcr_wr_r <= bcr_wr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        csr_rd_nxt = io_rd && csr_hit;
        bcr_rd_nxt = io_rd && bcr_hit;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            csr_rd_r <= 1'b0;
            bcr_rd_r <= 1'b0;
        end
        else
        begin
            csr_rd_r <= csr_rd_nxt;
            bcr_rd_r <= bcr_rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        demand_nxt = tx_demand_bit;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            demand_r <= 1'b0;
        end
        else
        begin
            demand_r <= demand_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One more stage so tx_poll leaves straight from a flop
    always_comb
    begin
        poll_out_nxt = cfg.poll;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            poll_out_r <= 1'b0;
        end
        else
        begin
            poll_out_r <= poll_out_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign io_rdata = rdata_r;
    assign reg_index = ptr_r;
    assign csr_wr = csr_wr_r;
    assign csr_rd = csr_rd_r;
    assign bcr_wr = bcr_wr_r;
    assign bcr_rd = bcr_rd_r;
    assign tx_poll_interval = poll_r;
    assign tx_poll = poll_out_r;
endmodule : indirect_csr_access

// File: test/host_io_model.sv
`timescale 1ns/1ns
module host_io_model
(
    input logic core_clk,
    input logic [31:0] io_rdata,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_addr,
    output logic [31:0] io_wdata
);
    initial
    begin
        {io_wr, io_rd, io_addr, io_wdata} = '0;
    end
    // Released lines carry the inverse so stale data never passes as fresh
    task automatic io_access(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge core_clk);
        io_wr <= wr;
        io_rd <= !wr;
        io_addr <= a;
        io_wdata <= d;
        @(posedge core_clk);
        {io_wr, io_rd} <= 2'b00;
        io_addr <= ~a;
        io_wdata <= ~d;
        @(posedge core_clk);
        #1 q = io_rdata;
    endtask : io_access
endmodule : host_io_model

// File: test/indirect_csr_access_props.sv
`timescale 1ns/1ns
module indirect_csr_access_props
(
    input logic core_clk,
    input logic reset,
    input logic soft_reset,
    input logic eeprom_busy,
    input logic eeprom_error,
    input logic init_cmd,
    input logic stop_cmd,
    input logic mem_wr,
    input logic tx_demand_bit,
    input logic double_word_io_mode,
    input logic io_wr,
    input logic io_rd,
    input logic [7:0] io_addr,
    input logic [31:0] io_wdata,
    input logic [31:0] io_rdata,
    input logic [7:0] reg_index,
    input logic bcr_rd,
    input logic csr_rd,
    input logic bcr_wr,
    input logic csr_wr,
    input logic [15:0] tx_poll_interval,
    input logic tx_poll
);
    logic [7:0] ptr_off;
    assign ptr_off = double_word_io_mode ? 8'h14 : 8'h12;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    sequence s_demand;
        tx_demand_bit ##3 tx_poll;
    endsequence
    property p_rst;
        $fell(reset) |-> reg_index == 8'h00 && tx_poll_interval == 16'h0000;
    endproperty
    property p_clear;
        eeprom_busy || eeprom_error || init_cmd |=> tx_poll_interval == 16'h0000;
    endproperty
    property p_ptr_wr;
        io_wr && !soft_reset && io_addr == ptr_off |=> reg_index == $past(io_wdata[7:0]);
    endproperty
    property p_ptr_rd;
        io_rd && io_addr == ptr_off |=> io_rdata == {24'h00_0000, $past(reg_index)};
    endproperty
    property p_csr_rd;
        io_rd && io_addr == 8'h10 |=> csr_rd && !bcr_rd;
    endproperty
    property p_bcr_rd;
        io_rd && io_addr == 8'h16 |=> bcr_rd == !$past(double_word_io_mode);
    endproperty
    property p_demand;
        tx_demand_bit |-> s_demand;
    endproperty
    property p_soft;
        soft_reset && !io_wr |=> reg_index == 8'h00;
    endproperty
    property p_csr_wr;
        io_wr && io_addr == 8'h10 |=> csr_wr && !bcr_wr;
    endproperty
    property p_bcr_wr;
        io_wr && io_addr == 8'h16 |=> bcr_wr == !$past(double_word_io_mode);
    endproperty
    property p_poll_wr;
        io_wr && io_addr == 8'h10 && reg_index == 8'h2F && !mem_wr && !init_cmd && !eeprom_busy && !eeprom_error
            |=> tx_poll_interval == $past(io_wdata[15:0]);
    endproperty
    property p_stop;
        stop_cmd && !soft_reset && !(io_wr && io_addr == ptr_off) |=> $stable(reg_index);
    endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    a_clear: assert property (p_clear) else $error("interval kept");
    a_ptr_wr: assert property (p_ptr_wr) else $error("pointer load");
    a_ptr_rd: assert property (p_ptr_rd) else $error("pointer read");
    a_csr_rd: assert property (p_csr_rd) else $error("status port");
    a_bcr_rd: assert property (p_bcr_rd) else $error("bus config port");
    a_demand: assert property (p_demand) else $error("demand poll");
    a_soft: assert property (p_soft) else $error("soft reset");
    a_csr_wr: assert property (p_csr_wr) else $error("status write");
    a_bcr_wr: assert property (p_bcr_wr) else $error("bus config write");
    a_poll_wr: assert property (p_poll_wr) else $error("interval via status port");
    a_stop: assert property (p_stop) else $error("stop moved pointer");
endmodule : indirect_csr_access_props
bind indirect_csr_access indirect_csr_access_props indirect_csr_access_props_inst
(
    .*
);

// File: test/tb_indirect_csr_access.sv
`timescale 1ns/1ns
module tb_indirect_csr_access;
    logic core_clk;
    logic reset = 1'b1;
    logic double_word_io_mode = 1'b0;
    logic [5:0] ctl = 6'h00;
    logic io_wr;
    logic io_rd;
    logic mem_wr = 1'b0;
    logic [7:0] io_addr;
    logic [31:0] io_wdata;
    logic [31:0] io_rdata;
    logic [31:0] q;
    logic [15:0] mem_addr = 16'h0188;
    logic [15:0] mem_wdata = 16'h0000;
    logic [7:0] reg_index;
    logic [15:0] tx_poll_interval;
    logic tx_poll;
    int n_fail;
    int total_checks;
    int cycles;
    int n;
    indirect_csr_access indirect_csr_access_inst
    (
        .*, .soft_reset(ctl[4]), .eeprom_busy(ctl[2]), .eeprom_error(ctl[1]), .init_cmd(ctl[0]),
        .stop_cmd(ctl[3]), .tx_demand_bit(ctl[5]), .csr_wr(), .csr_rd(), .bcr_wr(), .bcr_rd()
    );
    host_io_model host_io_model_inst
    (
        .*
    );
    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            n_fail++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host_io_model_inst.io_access(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask : rd
    task automatic mw(input logic [15:0] d);
        @(posedge core_clk);
        mem_wr <= 1'b1;
        mem_wdata <= d;
        @(posedge core_clk);
        mem_wr <= 1'b0;
        mem_wdata <= ~d;
    endtask : mw
    task automatic pulse(input logic [5:0] v);
        @(posedge core_clk);
        ctl <= v;
        @(posedge core_clk);
        ctl <= 6'h00;
    endtask : pulse
    // Bounded so a dead timer ends in a mismatch, not a hang
    task automatic wait_poll(output int k, input int lim);
        k = 0;
        do
        begin
            @(posedge core_clk);
            #1 k++;
        end
        while (tx_poll !== 1'b1 && k < lim);
    endtask : wait_poll
    task report_and_stop;
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        #1 chk({8'h00, reg_index, tx_poll_interval}, 32'h0000_0000);
        for (int m = 0; m < 2; m++)
        begin
            @(posedge core_clk);
            double_word_io_mode <= m[0];
            host_io_model_inst.io_access(1'b1, m[0] ? 8'h14 : 8'h12, 32'h0000_002F, q);
            rd(m[0] ? 8'h14 : 8'h12, 32'h0000_002F);
            rd(8'h10, 32'h0000_0000);
            host_io_model_inst.io_access(1'b0, 8'h16, 32'h0000_0000, q);
            host_io_model_inst.io_access(1'b1, 8'h16, 32'h0000_0000, q);
        end
        pulse(6'h01);
        host_io_model_inst.io_access(1'b1, 8'h10, 32'h0000_FFD0, q);
        rd(8'h10, 32'h0000_FFD0);
        mw(16'hFFE0);
        rd(8'h10, 32'h0000_FFE0);
        for (int i = 0; i < 2; i++)
        begin
            mw(i ? 16'hFFEF : 16'hFFE0);
            wait_poll(n, 200);
            wait_poll(n, 200);
            chk(n, 32'h0000_0020);
        end
        // Starts right after a poll; the write itself costs two cycles
        mw(16'h0000);
        wait_poll(n, 70000);
        chk(n, 32'h0000_FFFE);
        pulse(6'h20);
        wait_poll(n, 200);
        chk(n, 32'h0000_0002);
        for (int i = 0; i < 3; i++)
        begin
            mw(16'hFFE0);
            pulse(6'h01 << i);
            #1 chk({16'h0000, tx_poll_interval}, 32'h0000_0000);
        end
        pulse(6'h08);
        #1 chk({24'h00_0000, reg_index}, 32'h0000_002F);
        rd(8'h20, 32'h0000_0000);
        pulse(6'h10);
        #1 chk({24'h00_0000, reg_index}, 32'h0000_0000);
        report_and_stop();
    end
endmodule : tb_indirect_csr_access
